// file: camac_slave_defs.svh
// constants for the dataway slave: codes, bit positions, widths, resets
`ifndef CAMAC_SLAVE_DEFS_SVH
`define CAMAC_SLAVE_DEFS_SVH

// ============================================================
// widths
`define DW_DATA_W 24
`define FUNC_W 5
`define SUB_W 4
`define KIND_W 2
`define BUF_W 26
`define SYNC_W 37

// ============================================================
// function codes, all taken at subaddress zero
`define SUB_ZERO 4'h0
`define FN_READ 5'h00
`define FN_STATUS 5'h01
`define FN_BLOCK_READ 5'h04
`define FN_IDENT 5'h06
`define FN_CLEAR 5'h09
`define FN_WRITE 5'h10
`define FN_CLEAR_REBOOT 5'h11
`define FN_HEADER 5'h14
`define FN_EXTRA_HEADER 5'h16
`define FN_ENABLE_OFF 5'h18
`define FN_ENABLE_ON 5'h1A
`define FN_ON_OFF 5'h1C
`define FN_ON_ON 5'h1E

// ============================================================
// kind tag that travels with each written word
`define KIND_DATA 2'h0
`define KIND_HEADER 2'h1
`define KIND_EXTRA_HEADER 2'h2

// ============================================================
// status word bit positions, read line Rn sits at bit n-1
`define ST_TIMEOUT 23
`define ST_EXP_HDR 22
`define ST_HDR_SEQ 21
`define ST_C2B_SEQ 20
`define ST_B2C_SEQ 19
`define ST_IN_IR 18
`define ST_OUT_IR 17
`define ST_OUT_OR 16
`define ST_HEARTBEAT 12
`define ST_NO_ACCEPT 11
`define ST_LOCAL_MSG_N 10
`define ST_HOST_MSG_N 9
`define ST_NEED_INIT_N 8
`define ST_ON 6
`define ST_ENABLE 5

// ============================================================
// identification word, value is arbitrary
`define MODULE_ID 24'h00A5C3

// ============================================================
// reset values and buffer fill counts
`define ZERO_WORD 24'h000000
`define BUF_DEPTH 2'h2
`define BUF_ONE 2'h1
`define BUF_EMPTY 2'h0

`endif

// file: camac_slave_pkg.sv
// types shared by the dataway slave modules
package camac_slave_pkg;
`include "camac_slave_defs.svh"

  typedef enum logic [0:0] {
    CMD_IDLE = 1'b0,
    CMD_HOLD = 1'b1
  } cmd_state_t;

  typedef struct packed {
    logic [`SYNC_W-1:0] meta;
    logic [`SYNC_W-1:0] stable;
  } sync_state_t;

  typedef struct packed {
    logic [`BUF_W-1:0] word0;
    logic [`BUF_W-1:0] word1;
    logic [1:0] count;
  } buf_state_t;

  typedef struct packed {
    cmd_state_t st;
    logic s1_prev;
    logic x;
    logic q;
    logic [`DW_DATA_W-1:0] rdata;
    logic lam;
    logic enable_mode;
    logic on_mode;
    logic expecting_header;
    logic transaction_timeout;
    logic rd_taken;
    logic clr;
    logic reboot;
    logic push_valid;
    logic [`BUF_W-1:0] push_data;
  } main_state_t;
endpackage

// file: wr_stream_if.sv
// valid/ready word stream between the command decoder and its buffer
`include "camac_slave_defs.svh"

interface wr_stream_if;
  logic valid;
  logic ready;
  logic [`BUF_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: dataway_sync.sv
// two-stage synchroniser for every dataway line entering the clock domain
`include "camac_slave_defs.svh"

module dataway_sync (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // lines
  input wire logic [`SYNC_W-1:0] i_async,
  output logic [`SYNC_W-1:0] o_sync
);
  camac_slave_pkg::sync_state_t state_reg;
  camac_slave_pkg::sync_state_t state_next;

  // ============================================================
  // stage one feeds stage two only
  always_comb begin
    state_next = state_reg;
    state_next.meta = i_async;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_sync = state_reg.stable;
endmodule

// file: write_buffer.sv
// two-entry buffer for written words, so a stalled drain loses none
`include "camac_slave_defs.svh"

module write_buffer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // fill side
  wr_stream_if.snk fill,
  // drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [`BUF_W-1:0] o_data
);
  camac_slave_pkg::buf_state_t state_reg;
  camac_slave_pkg::buf_state_t state_next;
  logic push;
  logic pop;

  assign fill.ready = (state_reg.count != `BUF_DEPTH);
  assign o_valid = (state_reg.count != `BUF_EMPTY);
  assign o_data = state_reg.word0;
  assign push = fill.valid & fill.ready;
  assign pop = o_valid & i_ready;

  // ============================================================
  // word0 is always the head
  always_comb begin
    state_next = state_reg;
    if (pop) begin
      state_next.word0 = state_reg.word1;
    end
    if (push) begin
      if (state_reg.count == `BUF_EMPTY ||
          (pop && state_reg.count == `BUF_ONE)) begin
        state_next.word0 = fill.data;
      end else begin
        state_next.word1 = fill.data;
      end
    end
    state_next.count = state_reg.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

// file: camac_slave_command_status.sv
// dataway slave: command decode, X and Q answers, status word and LAM
`include "camac_slave_defs.svh"

module camac_slave_command_status (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESET_N,
  // dataway command lines
  input wire logic I_STATION,
  input wire logic I_STROBE1,
  input wire logic I_INIT_Z,
  input wire logic I_CLEAR_C,
  input wire logic [`FUNC_W-1:0] I_FUNC,
  input wire logic [`SUB_W-1:0] I_SUBADDR,
  input wire logic [`DW_DATA_W-1:0] I_WRITE_DATA,
  // dataway answer lines
  output logic [`DW_DATA_W-1:0] O_READ_DATA,
  output logic O_X_RESP,
  output logic O_Q_RESP,
  output logic O_LAM,
  // sequencing state from the transfer logic
  input wire logic I_HEADER_SEQUENCE,
  input wire logic I_CRATE_TO_BUS_SEQUENCE,
  input wire logic I_BUS_TO_CRATE_SEQUENCE,
  input wire logic I_CRATE_WRITE_IN_PROGRESS,
  input wire logic I_OUTBOUND_TO_READ_REG_TRANSFER,
  input wire logic I_TRANSFER_TIMEOUT,
  // fifo flags
  input wire logic I_INBOUND_FIFO_INPUT_READY,
  input wire logic I_OUTBOUND_FIFO_INPUT_READY,
  input wire logic I_OUTBOUND_FIFO_OUTPUT_READY,
  // processor status
  input wire logic I_HEARTBEAT,
  input wire logic I_CANNOT_ACCEPT_DATA,
  input wire logic I_LOCAL_MASTER_MESSAGE_PENDING_N,
  input wire logic I_HOST_MESSAGE_PENDING_N,
  input wire logic I_NEEDS_INITIALISE_N,
  // read registers
  input wire logic [`DW_DATA_W-1:0] I_READ_REG_DATA,
  output logic O_READ_TAKEN,
  // written words toward the write registers
  output logic O_WR_VALID,
  input wire logic I_WR_READY,
  output logic [`DW_DATA_W-1:0] O_WR_DATA,
  output logic [`KIND_W-1:0] O_WR_KIND,
  // mode and clear outputs
  output logic O_ENABLE_MODE,
  output logic O_ON_MODE,
  output logic O_MODULE_CLEAR,
  output logic O_REBOOT
);
  camac_slave_pkg::main_state_t state_reg;
  camac_slave_pkg::main_state_t state_next;

  // ============================================================
  // dataway lines are asynchronous to the core clock
  // all share one synchroniser; function, subaddress and data settle
  // before the strobe, so skew between the bits does no harm
  logic [`SYNC_W-1:0] sync_out;
  logic dw_station;
  logic dw_s1;
  logic dw_z;
  logic dw_c;
  logic [`FUNC_W-1:0] dw_func;
  logic [`SUB_W-1:0] dw_sub;
  logic [`DW_DATA_W-1:0] dw_wdata;

  dataway_sync u_sync (
    .i_clk(I_CORE_CLK),
    .i_reset_n(I_RESET_N),
    .i_async({I_STATION, I_STROBE1, I_INIT_Z, I_CLEAR_C,
              I_FUNC, I_SUBADDR, I_WRITE_DATA}),
    .o_sync(sync_out)
  );

  assign {dw_station, dw_s1, dw_z, dw_c, dw_func, dw_sub, dw_wdata} =
    sync_out;

  // ============================================================
  // write buffer
  // the kind tag rides above the data word in each entry
  wr_stream_if wr_link ();
  logic [`BUF_W-1:0] buf_out;

  assign wr_link.valid = state_reg.push_valid;
  assign wr_link.data = state_reg.push_data;

  write_buffer u_buf (
    .i_clk(I_CORE_CLK),
    .i_reset_n(I_RESET_N),
    .fill(wr_link.snk),
    .o_valid(O_WR_VALID),
    .i_ready(I_WR_READY),
    .o_data(buf_out)
  );

  assign O_WR_KIND = buf_out[`BUF_W-1:`DW_DATA_W];
  assign O_WR_DATA = buf_out[`DW_DATA_W-1:0];

  // ============================================================
  // status word
  // sampled once at the decode edge, so a read shows one snapshot
  logic [`DW_DATA_W-1:0] status_word;

  always_comb begin
    status_word = `ZERO_WORD;
    status_word[`ST_TIMEOUT] = state_reg.transaction_timeout;
    status_word[`ST_EXP_HDR] = state_reg.expecting_header;
    status_word[`ST_HDR_SEQ] = I_HEADER_SEQUENCE;
    status_word[`ST_C2B_SEQ] = I_CRATE_TO_BUS_SEQUENCE;
    status_word[`ST_B2C_SEQ] = I_BUS_TO_CRATE_SEQUENCE;
    status_word[`ST_IN_IR] = I_INBOUND_FIFO_INPUT_READY;
    status_word[`ST_OUT_IR] = I_OUTBOUND_FIFO_INPUT_READY;
    status_word[`ST_OUT_OR] = I_OUTBOUND_FIFO_OUTPUT_READY;
    status_word[`ST_HEARTBEAT] = I_HEARTBEAT;
    status_word[`ST_NO_ACCEPT] = I_CANNOT_ACCEPT_DATA;
    status_word[`ST_LOCAL_MSG_N] = I_LOCAL_MASTER_MESSAGE_PENDING_N;
    status_word[`ST_HOST_MSG_N] = I_HOST_MESSAGE_PENDING_N;
    status_word[`ST_NEED_INIT_N] = I_NEEDS_INITIALISE_N;
    status_word[`ST_ON] = state_reg.on_mode;
    status_word[`ST_ENABLE] = state_reg.enable_mode;
  end

  // ============================================================
  // conditional Q terms
  // every term is sampled at the decode edge with the dataway lines
  logic read_ok;
  logic write_ok;
  logic header_ok;
  logic extra_ok;

  assign read_ok = ~I_OUTBOUND_TO_READ_REG_TRANSFER & ~I_HEADER_SEQUENCE;
  // buffer room is an extra term so a refused word is never dropped
  assign write_ok = ~I_CRATE_WRITE_IN_PROGRESS &
    ~I_OUTBOUND_FIFO_OUTPUT_READY & wr_link.ready;
  // a header also needs the flag; an extra header needs the header sequence idle
  assign header_ok = write_ok & state_reg.expecting_header;
  assign extra_ok = write_ok & ~I_HEADER_SEQUENCE;

  // ============================================================
  // command sequencing
  // a strobe edge while an answer is held is ignored, and the strobe
  // must be seen low again before its next rise counts
  logic s1_rise;
  logic cmd_start;
  logic do_clear;

  assign s1_rise = dw_s1 & ~state_reg.s1_prev;
  assign cmd_start = (state_reg.st == camac_slave_pkg::CMD_IDLE) &
    s1_rise & dw_station;

  always_comb begin
    state_next = state_reg;
    do_clear = dw_z | dw_c;
    state_next.s1_prev = dw_s1;
    state_next.rd_taken = 1'b0;
    state_next.reboot = 1'b0;
    state_next.push_valid = 1'b0;
    unique case (state_reg.st)
      camac_slave_pkg::CMD_IDLE: begin
        if (cmd_start) begin
          state_next.st = camac_slave_pkg::CMD_HOLD;
          // answers are cleared first, so a refused command reads zero
          state_next.x = 1'b0;
          state_next.q = 1'b0;
          state_next.rdata = `ZERO_WORD;
          // only subaddress zero is decoded; others answer nothing
          if (dw_sub == `SUB_ZERO) begin
            case (dw_func)
              // reads answer Q only when the read registers may be taken
              `FN_READ, `FN_BLOCK_READ: begin
                state_next.x = 1'b1;
                state_next.q = read_ok;
                if (read_ok) begin
                  state_next.rdata = I_READ_REG_DATA;
                  state_next.rd_taken = 1'b1;
                end
              end

              // status and identity reads always answer Q
              `FN_STATUS: begin
                state_next.x = 1'b1;
                state_next.q = 1'b1;
                state_next.rdata = status_word;
              end

              `FN_IDENT: begin
                state_next.x = 1'b1;
                state_next.q = 1'b1;
                state_next.rdata = `MODULE_ID;
              end

              // clears act through do_clear below, shared with Z and C
              `FN_CLEAR: begin
                state_next.x = 1'b1;
                state_next.q = 1'b1;
                do_clear = 1'b1;
              end

              `FN_CLEAR_REBOOT: begin
                state_next.x = 1'b1;
                state_next.q = 1'b1;
                do_clear = 1'b1;
                state_next.reboot = 1'b1;
              end

              // a refused write leaves the buffer and the flags untouched
              `FN_WRITE: begin
                state_next.x = 1'b1;
                state_next.q = write_ok;
                state_next.push_valid = write_ok;
                state_next.push_data = {`KIND_DATA, dw_wdata};
              end

              `FN_HEADER: begin
                state_next.x = 1'b1;
                state_next.q = header_ok;
                state_next.push_valid = header_ok;
                state_next.push_data = {`KIND_HEADER, dw_wdata};
                if (header_ok) begin
                  state_next.expecting_header = 1'b0;
                end
              end

              `FN_EXTRA_HEADER: begin
                state_next.x = 1'b1;
                state_next.q = extra_ok;
                state_next.push_valid = extra_ok;
                state_next.push_data = {`KIND_EXTRA_HEADER, dw_wdata};
              end

              // mode bits change only on an accepted command or on Z or C
              `FN_ENABLE_OFF: begin
                state_next.x = 1'b1;
                state_next.q = 1'b1;
                state_next.enable_mode = 1'b0;
              end

              `FN_ENABLE_ON: begin
                state_next.x = 1'b1;
                state_next.q = 1'b1;
                state_next.enable_mode = 1'b1;
              end

              `FN_ON_OFF: begin
                state_next.x = 1'b1;
                state_next.q = 1'b1;
                state_next.on_mode = 1'b0;
              end

              `FN_ON_ON: begin
                state_next.x = 1'b1;
                state_next.q = 1'b1;
                state_next.on_mode = 1'b1;
              end

              // unknown codes answer neither X nor Q
              default: begin
                state_next.x = 1'b0;
              end
            endcase
          end
        end
      end
      camac_slave_pkg::CMD_HOLD: begin
        // answers stand until the controller drops station select
        if (!dw_station) begin
          state_next.st = camac_slave_pkg::CMD_IDLE;
          state_next.x = 1'b0;
          state_next.q = 1'b0;
          state_next.rdata = `ZERO_WORD;
        end
      end
    endcase
    // Z and C act as a module clear without the reboot pulse
    state_next.clr = do_clear;
    if (do_clear) begin
      state_next.enable_mode = 1'b0;
      state_next.on_mode = 1'b0;
      state_next.expecting_header = 1'b1;
    end
    // a timeout arriving with a clear survives it
    state_next.transaction_timeout = I_TRANSFER_TIMEOUT |
      (state_reg.transaction_timeout & ~do_clear);
    // the host message and needs-initialise bits ask for attention
    // heartbeat low means the processor has stopped, which also asks
    state_next.lam = ~I_HEARTBEAT | ~I_HOST_MESSAGE_PENDING_N |
      ~I_NEEDS_INITIALISE_N;
  end

  // ============================================================
  // state register
  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_reg <= '0;
      // the header flag leaves reset set, as after a module clear
      state_reg.expecting_header <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ============================================================
  // outputs
  // every answer line comes straight from a flip-flop
  assign O_READ_DATA = state_reg.rdata;
  assign O_X_RESP = state_reg.x;
  assign O_Q_RESP = state_reg.q;
  assign O_LAM = state_reg.lam;
  assign O_READ_TAKEN = state_reg.rd_taken;
  assign O_ENABLE_MODE = state_reg.enable_mode;
  assign O_ON_MODE = state_reg.on_mode;
  assign O_MODULE_CLEAR = state_reg.clr;
  assign O_REBOOT = state_reg.reboot;
endmodule

// file: camac_slave_sva.sv
// port-level checker for the dataway slave, bound to its top module
`include "camac_slave_defs.svh"

module slave_checker (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESET_N,
  // dataway
  input wire logic I_STATION,
  input wire logic [`FUNC_W-1:0] I_FUNC,
  input wire logic [`SUB_W-1:0] I_SUBADDR,
  input wire logic [`DW_DATA_W-1:0] O_READ_DATA,
  input wire logic O_X_RESP,
  input wire logic O_Q_RESP,
  input wire logic O_LAM,
  // sequencing and status
  input wire logic I_HEADER_SEQUENCE,
  input wire logic I_CRATE_WRITE_IN_PROGRESS,
  input wire logic I_OUTBOUND_TO_READ_REG_TRANSFER,
  input wire logic I_OUTBOUND_FIFO_OUTPUT_READY,
  input wire logic I_HEARTBEAT,
  input wire logic I_HOST_MESSAGE_PENDING_N,
  input wire logic I_NEEDS_INITIALISE_N
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESET_N);
  // answers are only trusted while the station stays selected
  wire logic sel = O_X_RESP && I_STATION;

  // ============================================================
  // answers
  chk_q_needs_x: assert property (O_Q_RESP |-> O_X_RESP)
    else $error("Q answered without X");
  chk_sub_refused: assert property (
    I_STATION && I_SUBADDR != `SUB_ZERO |-> !O_X_RESP)
    else $error("nonzero subaddress answered");
  chk_always_q: assert property (
    sel && I_FUNC inside {`FN_STATUS, `FN_IDENT, `FN_CLEAR,
      `FN_CLEAR_REBOOT, `FN_ENABLE_OFF, `FN_ENABLE_ON, `FN_ON_OFF,
      `FN_ON_ON} |-> O_Q_RESP)
    else $error("unconditional command without Q");
  chk_ident_word: assert property (
    sel && I_FUNC == `FN_IDENT |-> O_READ_DATA == `MODULE_ID)
    else $error("identification word wrong");
  chk_status_gaps: assert property (
    sel && I_FUNC == `FN_STATUS |->
      (O_READ_DATA & 24'h00E09F) == 24'h000000)
    else $error("unused status bit set");
  // the answer rises one edge after the decode edge that took the terms
  chk_read_block: assert property (
    $rose(O_X_RESP) && I_FUNC inside {`FN_READ, `FN_BLOCK_READ} &&
      ($past(I_HEADER_SEQUENCE) || $past(I_OUTBOUND_TO_READ_REG_TRANSFER))
      |-> !O_Q_RESP)
    else $error("read answered Q while blocked");
  chk_write_block: assert property (
    $rose(O_X_RESP) &&
      I_FUNC inside {`FN_WRITE, `FN_HEADER, `FN_EXTRA_HEADER} &&
      ($past(I_CRATE_WRITE_IN_PROGRESS) ||
      $past(I_OUTBOUND_FIFO_OUTPUT_READY)) |-> !O_Q_RESP)
    else $error("write answered Q while blocked");
  chk_lam_sources: assert property ($past(I_RESET_N) |->
    O_LAM == (!$past(I_HEARTBEAT) || !$past(I_HOST_MESSAGE_PENDING_N) ||
      !$past(I_NEEDS_INITIALISE_N)))
    else $error("LAM does not follow its sources");

  cover property ($rose(O_Q_RESP));
  cover property ($rose(O_X_RESP) && !O_Q_RESP);
  cover property (O_LAM);
endmodule

bind camac_slave_command_status slave_checker chk (
  .I_CORE_CLK, .I_RESET_N, .I_STATION, .I_FUNC, .I_SUBADDR, .O_READ_DATA,
  .O_X_RESP, .O_Q_RESP, .O_LAM, .I_HEADER_SEQUENCE,
  .I_CRATE_WRITE_IN_PROGRESS, .I_OUTBOUND_TO_READ_REG_TRANSFER,
  .I_OUTBOUND_FIFO_OUTPUT_READY, .I_HEARTBEAT, .I_HOST_MESSAGE_PENDING_N,
  .I_NEEDS_INITIALISE_N);

// file: crate_controller.sv
// crate controller model: issues dataway commands and takes the answers
`include "camac_slave_defs.svh"

module crate_controller (
  // clock
  input wire logic i_clk,
  // answers
  input wire logic i_x,
  input wire logic i_q,
  input wire logic [`DW_DATA_W-1:0] i_r,
  // command lines
  output logic o_n,
  output logic o_s1,
  output logic o_z,
  output logic o_c,
  output logic [`FUNC_W-1:0] o_f,
  output logic [`SUB_W-1:0] o_a,
  output logic [`DW_DATA_W-1:0] o_w
);
  timeunit 1ns;
  timeprecision 1ns;
  logic x;
  logic q;
  logic [`DW_DATA_W-1:0] r;

  initial begin
    {o_n, o_s1, o_z, o_c, o_f, o_a, o_w} = '0;
  end

  // ============================================================
  // one command; answers land within four edges, six leaves margin
  task automatic cmd(input logic [4:0] f, input logic [3:0] a,
                     input logic [23:0] w);
    @(posedge i_clk);
    o_n <= 1'b1;
    o_f <= f;
    o_a <= a;
    o_w <= w;
    @(posedge i_clk);
    o_s1 <= 1'b1;
    repeat (6) @(posedge i_clk);
    x = i_x;
    q = i_q;
    r = i_r;
    o_s1 <= 1'b0;
    o_n <= 1'b0;
    // released lines must not keep showing the last command
    o_f <= ~f;
    o_a <= ~a;
    o_w <= ~w;
    repeat (6) @(posedge i_clk);
  endtask

  task automatic pulse(input logic use_c);
    @(posedge i_clk);
    if (use_c) o_c <= 1'b1;
    else o_z <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_z <= 1'b0;
    o_c <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
endmodule

// file: testbench.sv
// self-checking bench for the dataway slave
`include "camac_slave_defs.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  mismatches++; $display("unexpected at %0t: %h expected %h", \
  $time, (a), (e)); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, rdy, n, s1, z, c, x, q, lam, wv, en, on;
  logic [13:0] sin;
  logic [4:0] f;
  logic [3:0] a;
  logic [1:0] kind;
  logic [23:0] rr, w, rd, wdat;
  logic tk, clr, rb;
  int mismatches, comparisons, cyc;
  int taken_cnt, clear_cnt, reboot_cnt;

  crate_controller ctl (.i_clk(clk), .i_x(x), .i_q(q), .i_r(rd), .o_n(n),
    .o_s1(s1), .o_z(z), .o_c(c), .o_f(f), .o_a(a), .o_w(w));

  camac_slave_command_status uut (
    .I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_STATION(n), .I_STROBE1(s1),
    .I_INIT_Z(z), .I_CLEAR_C(c), .I_FUNC(f), .I_SUBADDR(a),
    .I_WRITE_DATA(w), .O_READ_DATA(rd), .O_X_RESP(x), .O_Q_RESP(q),
    .O_LAM(lam), .I_HEADER_SEQUENCE(sin[0]),
    .I_CRATE_TO_BUS_SEQUENCE(sin[1]), .I_BUS_TO_CRATE_SEQUENCE(sin[2]),
    .I_CRATE_WRITE_IN_PROGRESS(sin[3]),
    .I_OUTBOUND_TO_READ_REG_TRANSFER(sin[4]),
    .I_TRANSFER_TIMEOUT(sin[5]), .I_INBOUND_FIFO_INPUT_READY(sin[6]),
    .I_OUTBOUND_FIFO_INPUT_READY(sin[7]),
    .I_OUTBOUND_FIFO_OUTPUT_READY(sin[8]), .I_HEARTBEAT(sin[9]),
    .I_CANNOT_ACCEPT_DATA(sin[10]),
    .I_LOCAL_MASTER_MESSAGE_PENDING_N(sin[11]),
    .I_HOST_MESSAGE_PENDING_N(sin[12]), .I_NEEDS_INITIALISE_N(sin[13]),
    .I_READ_REG_DATA(rr), .O_READ_TAKEN(tk), .O_WR_VALID(wv),
    .I_WR_READY(rdy), .O_WR_DATA(wdat), .O_WR_KIND(kind),
    .O_ENABLE_MODE(en), .O_ON_MODE(on), .O_MODULE_CLEAR(clr), .O_REBOOT(rb));

  // ============================================================
  // helpers
  function automatic logic [23:0] stat(input logic [13:0] s,
                                       input logic t, e, o, b);
    stat = {t, e, s[0], s[1], s[2], s[6], s[7], s[8], 3'h0, s[9], s[10],
            s[11], s[12], s[13], 1'h0, o, b, 5'h00};
  endfunction

  task automatic op(input logic [4:0] fc, input logic [23:0] wd,
                    input logic qe);
    ctl.cmd(fc, `SUB_ZERO, wd);
    `CHK(ctl.x, 1'b1)
    `CHK(ctl.q, qe)
  endtask

  task automatic pop;
    @(posedge clk);
    rdy <= 1'b1;
    @(posedge clk);
    rdy <= 1'b0;
    @(negedge clk);
  endtask

  // pulses are tallied on every edge so none slips past a check
  always @(posedge clk) begin
    taken_cnt += tk;
    clear_cnt += clr;
    reboot_cnt += rb;
  end

  // ============================================================
  // scenarios
  task automatic t_status;
    sin <= 14'h3FFF;
    @(posedge clk);
    sin[5] <= 1'b0;
    op(`FN_STATUS, 24'h0, 1'b1);
    `CHK(ctl.r, stat(14'h3FFF, 1, 1, 0, 0))
    sin <= 14'h0000;
    op(`FN_STATUS, 24'h0, 1'b1);
    `CHK(ctl.r, stat(14'h0000, 1, 1, 0, 0))
    sin <= 14'h3A00;
  endtask

  task automatic t_modes;
    op(`FN_ENABLE_ON, 24'h0, 1'b1);
    `CHK(en, 1'b1)
    op(`FN_ON_ON, 24'h0, 1'b1);
    `CHK(on, 1'b1)
    op(`FN_STATUS, 24'h0, 1'b1);
    `CHK(ctl.r, stat(14'h3A00, 1, 1, 1, 1))
    op(`FN_ENABLE_OFF, 24'h0, 1'b1);
    op(`FN_ON_OFF, 24'h0, 1'b1);
    `CHK({en, on}, 2'b00)
  endtask

  task automatic t_read;
    rr <= 24'h5A1C3E;
    op(`FN_READ, 24'h0, 1'b1);
    `CHK(ctl.r, 24'h5A1C3E)
    sin[0] <= 1'b1;
    op(`FN_BLOCK_READ, 24'h0, 1'b0);
    sin[0] <= 1'b0;
    sin[4] <= 1'b1;
    op(`FN_READ, 24'h0, 1'b0);
    sin[4] <= 1'b0;
    op(`FN_BLOCK_READ, 24'h0, 1'b1);
    `CHK(ctl.r, 24'h5A1C3E)
    `CHK(taken_cnt, 2)
  endtask

  task automatic t_write;
    op(`FN_HEADER, 24'h010403, 1'b1);
    op(`FN_HEADER, 24'h111111, 1'b0);
    sin[3] <= 1'b1;
    op(`FN_WRITE, 24'h222222, 1'b0);
    sin[3] <= 1'b0;
    sin[8] <= 1'b1;
    op(`FN_WRITE, 24'h333333, 1'b0);
    sin[8] <= 1'b0;
    sin[0] <= 1'b1;
    op(`FN_EXTRA_HEADER, 24'h444444, 1'b0);
    sin[0] <= 1'b0;
    op(`FN_WRITE, 24'h302010, 1'b1);
    // two words held with the drain stalled: the buffer must refuse
    op(`FN_EXTRA_HEADER, 24'h555555, 1'b0);
    `CHK({wv, kind, wdat}, {1'b1, `KIND_HEADER, 24'h010403})
    pop;
    `CHK({wv, kind, wdat}, {1'b1, `KIND_DATA, 24'h302010})
    pop;
    `CHK(wv, 1'b0)
    op(`FN_EXTRA_HEADER, 24'h555555, 1'b1);
    `CHK({wv, kind, wdat}, {1'b1, `KIND_EXTRA_HEADER, 24'h555555})
    pop;
  endtask

  task automatic t_clear;
    rdy <= 1'b1;
    op(`FN_ENABLE_ON, 24'h0, 1'b1);
    op(`FN_CLEAR, 24'h0, 1'b1);
    `CHK(en, 1'b0)
    `CHK(clear_cnt, 1)
    op(`FN_STATUS, 24'h0, 1'b1);
    `CHK(ctl.r, stat(14'h3A00, 0, 1, 0, 0))
    op(`FN_CLEAR_REBOOT, 24'h0, 1'b1);
    `CHK(reboot_cnt, 1)
    for (int i = 0; i < 2; i++) begin
      op(`FN_HEADER, 24'h0, 1'b1);
      ctl.pulse(i[0]);
      op(`FN_STATUS, 24'h0, 1'b1);
      `CHK(ctl.r[22], 1'b1)
    end
    `CHK(clear_cnt, 10)
    rdy <= 1'b0;
  endtask

  task automatic t_lam;
    logic [13:0] pat [4] = '{14'h3800, 14'h2A00, 14'h1A00, 14'h3200};
    for (int i = 0; i < 4; i++) begin
      sin <= pat[i];
      repeat (3) @(posedge clk);
      `CHK(lam, i < 3)
    end
    sin <= 14'h3A00;
  endtask

  task automatic t_refused;
    op(`FN_IDENT, 24'h0, 1'b1);
    `CHK(ctl.r, `MODULE_ID)
    ctl.cmd(`FN_STATUS, 4'h1, 24'h0);
    `CHK({ctl.x, ctl.q, ctl.r}, 26'h0)
    ctl.cmd(5'h02, `SUB_ZERO, 24'h0);
    `CHK({ctl.x, ctl.q}, 2'b00)
  endtask

  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ============================================================
  // clock, timeout and main sequence
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // the whole run needs about five hundred cycles
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 4000) begin
        mismatches++;
        stop_test;
      end
    end
  end

  initial begin
    rst_n = 1'b0;
    rdy = 1'b0;
    rr = 24'h000000;
    sin = 14'h3A00;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_status;
    t_modes;
    t_read;
    t_write;
    t_clear;
    t_lam;
    t_refused;
    stop_test;
  end
endmodule
